// ---- hw/irq_pkg.sv ----
// package: constants, types and summary of the interrupt output block
// Summary of operation
// - event in normal/stop gives 100 us low pulse
// - at least 100 us high between pulses
// - pulses never change the operating mode
// - class 0: only wake status bits interrupt
// - wake event interrupts only if source enabled
// - wake sources: can, wake pin, timer, gpio
// - class 1: failures also interrupt, except level/id
// - reset and fail-safe causing bits never interrupt
// - no pulse in restart, fail-safe or sleep
// - stop entry with pending wake bits pulses
// - status registers update at pulse falling edge
// - latched events held until host clears them
// - init mode samples pin through 10 us filter
// - wake pin change qualifies after 16 us stable
// - both wake pin edges are signalled
// - restart mode gpio wake sets flag, no pulse
package irq_pkg;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int CLK_HZ          = 10_000_000;
  localparam int PULSE_US        = 100;
  localparam int GAP_US          = 100;
  localparam int WAKE_FILT_US    = 16;
  localparam int CFG_FILT_US     = 10;
  localparam int PULSE_CYC       = (PULSE_US * (CLK_HZ / 1_000_000));
  localparam int GAP_CYC         = (GAP_US * (CLK_HZ / 1_000_000));
  localparam int WAKE_FILT_CYC   = (WAKE_FILT_US * (CLK_HZ / 1_000_000));
  localparam int CFG_FILT_CYC    = (CFG_FILT_US * (CLK_HZ / 1_000_000));
  localparam int CNT_W           = 11;

  // ---------------------------------------------------------------------
  // wake source bit positions
  // ---------------------------------------------------------------------
  localparam int WK_CAN          = 0;
  localparam int WK_PIN          = 1;
  localparam int WK_TIMER        = 2;
  localparam int WK_GPIO         = 3;
  localparam int WK_N            = 4;
  localparam int FAIL_N          = 8;
  localparam logic [WK_N-1:0]   WAKE_RST = 4'h0;
  localparam logic [FAIL_N-1:0] FAIL_RST = 8'h00;

  // ---------------------------------------------------------------------
  // modes and states
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_INIT     = 3'h0,
    MODE_NORMAL   = 3'h1,
    MODE_STOP     = 3'h2,
    MODE_SLEEP    = 3'h3,
    MODE_RESTART  = 3'h4,
    MODE_FAILSAFE = 3'h5
  } sbc_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_PULSE = 3'h2,
    ST_GAP   = 3'h4
  } irq_state_t;

  // ---------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic can;
    logic pin;
    logic timer;
    logic gpio;
  } wake_src_t;

  typedef struct packed {
    logic [WK_N-1:0]   wake;
    logic [FAIL_N-1:0] fail;
  } status_t;

endpackage

// ---- hw/level_filter.sv ----
// stable-level filter: output follows input after it is steady for FILT cycles
`timescale 1ns/1ps
module level_filter #(
  parameter int FILT = 160
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // level in and qualified level out
  input  wire logic din,
  output logic      dout,
  output logic      change
);

  logic [irq_pkg::CNT_W-1:0] cnt_reg;

  // restart count on every crossing, so glitches shorter than the filter vanish
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      dout    <= 1'b0;
      change  <= 1'b0;
    end else begin
      change <= 1'b0;
      if (din == dout) begin
        cnt_reg <= '0;
      end else if (cnt_reg == irq_pkg::CNT_W'(FILT - 1)) begin
        cnt_reg <= '0;
        dout    <= din;
        change  <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule

// ---- hw/sbc_interrupt_output.sv ----
// interrupt output logic: pulse timing, source gating and status latching
`timescale 1ns/1ps
module sbc_interrupt_output #(
  parameter int PULSE_CYC     = irq_pkg::PULSE_CYC,
  parameter int GAP_CYC       = irq_pkg::GAP_CYC,
  parameter int WAKE_FILT_CYC = irq_pkg::WAKE_FILT_CYC,
  parameter int CFG_FILT_CYC  = irq_pkg::CFG_FILT_CYC
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  // operating mode, owned by the mode controller
  input  wire irq_pkg::sbc_mode_t          mode,
  // configuration
  input  wire logic                        class_select,
  input  wire irq_pkg::wake_src_t          wake_enable,
  input  wire logic                        gpio_is_wake,
  // raw events
  input  wire logic                        can_wake,
  input  wire logic                        timer_wake,
  input  wire logic                        wake_pin,
  input  wire logic                        gpio_pin,
  input  wire logic [irq_pkg::FAIL_N-1:0]  fail_event,
  input  wire logic [irq_pkg::FAIL_N-1:0]  fail_irq_allow,
  // host clear strobes
  input  wire logic                        clear_wake_primary,
  input  wire logic                        clear_wake_secondary,
  input  wire logic                        clear_fail,
  // interrupt pin (pin read back for configuration sampling)
  input  wire logic                        irq_pin_in,
  output logic                             irq_out_n,
  output logic                             irq_out_en,
  // status seen by the host
  output irq_pkg::status_t                 status_visible,
  output logic [1:0]                       wake_level_status,
  output logic                             gpio_wake_event,
  output logic                             hw_config_sel,
  output logic                             wake_device
);

  // ---------------------------------------------------------------------
  // input qualification
  // ---------------------------------------------------------------------
  logic wk_lvl;
  logic wk_chg;
  logic gp_lvl;
  logic gp_chg;
  logic cfg_lvl;

  // both edges of the filtered level count as wake events
  level_filter #(.FILT(WAKE_FILT_CYC)) u_wk_filt (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (wake_pin),
    .dout   (wk_lvl),
    .change (wk_chg)
  );

  level_filter #(.FILT(WAKE_FILT_CYC)) u_gp_filt (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (gpio_pin & gpio_is_wake),
    .dout   (gp_lvl),
    .change (gp_chg)
  );

  level_filter #(.FILT(CFG_FILT_CYC)) u_cfg_filt (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (irq_pin_in),
    .dout   (cfg_lvl),
    .change ()
  );

  // ---------------------------------------------------------------------
  // source gating
  // ---------------------------------------------------------------------
  logic [irq_pkg::WK_N-1:0] wake_hit;
  logic [irq_pkg::WK_N-1:0] en_vec;
  logic                     pulse_ok;
  logic                     gpio_ev;

  // gpio edges count only while the pin is configured as a wake input
  assign gpio_ev = gp_chg & gpio_is_wake;
  // enable vector in wake-bit order; the gpio enable also needs wake configuration
  assign en_vec  = {wake_enable.gpio & gpio_is_wake, wake_enable.timer,
                    wake_enable.pin, wake_enable.can};
  // four wake sources, each only when enabled as a wake source
  assign wake_hit = {gpio_ev, timer_wake, wk_chg, can_wake} & en_vec;
  // pulses only in normal and stop; restart, fail-safe and sleep stay quiet
  assign pulse_ok = (mode == irq_pkg::MODE_NORMAL) || (mode == irq_pkg::MODE_STOP);

  // ---------------------------------------------------------------------
  // pending event latch (internal, before the visible copy)
  // ---------------------------------------------------------------------
  logic [irq_pkg::WK_N-1:0]   wake_lat_reg;
  logic [irq_pkg::FAIL_N-1:0] fail_lat_reg;
  logic [irq_pkg::FAIL_N-1:0] fail_irq;
  logic                       wake_clr_p;
  logic                       wake_clr_s;
  logic                       fail_clr;

  // class 1 lets allowed failures through; the exception bits are kept out by mask
  assign fail_irq = fail_event & fail_irq_allow & {irq_pkg::FAIL_N{class_select}};

  // set wins over a host clear in the same cycle; held until cleared
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_lat_reg <= irq_pkg::WAKE_RST;
    end else begin
      for (int i = 0; i < irq_pkg::WK_N; i++) begin
        if (wake_hit[i]) begin
          wake_lat_reg[i] <= 1'b1;
        end else if ((i == irq_pkg::WK_GPIO) ? wake_clr_s : wake_clr_p) begin
          wake_lat_reg[i] <= 1'b0;
        end
      end
    end
  end

  // failures latch in every class; the class only decides about the pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fail_lat_reg <= irq_pkg::FAIL_RST;
    end else begin
      fail_lat_reg <= (fail_clr ? '0 : fail_lat_reg) | fail_event;
    end
  end

  // ---------------------------------------------------------------------
  // request generation
  // ---------------------------------------------------------------------
  logic             req_reg;
  logic             stop_q_reg;
  logic             stop_entry;
  logic             fall;
  logic             pending_wake;

  // stop entry is the first cycle of the stop level; pending wake bits re-announce
  assign stop_entry   = (mode == irq_pkg::MODE_STOP) && !stop_q_reg;
  assign pending_wake = |(wake_lat_reg & en_vec);

  // previous-cycle copy of the stop level for the entry edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_q_reg <= 1'b0;
    end else begin
      stop_q_reg <= (mode == irq_pkg::MODE_STOP);
    end
  end

  // events outside normal/stop are dropped so a mode return does not fire stale pulses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_reg <= 1'b0;
    end else if (!pulse_ok) begin
      req_reg <= 1'b0;
    end else if ((|wake_hit) || (|fail_irq) || (stop_entry && pending_wake)) begin
      req_reg <= 1'b1;
    end else if (fall) begin
      req_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // pulse and gap sequencer
  // ---------------------------------------------------------------------
  irq_pkg::irq_state_t       state_reg;
  irq_pkg::irq_state_t       state_next;
  logic [irq_pkg::CNT_W-1:0] cnt_reg;
  logic                      cnt_done;

  // terminal counts of the two timed phases share one counter
  assign cnt_done = (state_reg == irq_pkg::ST_PULSE) ?
                    (cnt_reg == irq_pkg::CNT_W'(PULSE_CYC - 1)) :
                    (cnt_reg == irq_pkg::CNT_W'(GAP_CYC - 1));
  assign fall     = (state_reg == irq_pkg::ST_IDLE) && (state_next == irq_pkg::ST_PULSE);

  // a clear that meets a snapshot is held back from the latch as well, so the
  // visible copy and the latch agree and the events just taken are not lost
  assign wake_clr_p = clear_wake_primary && !fall;
  assign wake_clr_s = clear_wake_secondary && !fall;
  assign fail_clr   = clear_fail && !fall;

  // a request during the gap waits in req_reg until the gap has run out
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      irq_pkg::ST_IDLE: begin
        if (req_reg && pulse_ok) begin
          state_next = irq_pkg::ST_PULSE;
        end
      end
      irq_pkg::ST_PULSE: begin
        if (cnt_done) begin
          state_next = irq_pkg::ST_GAP;
        end
      end
      irq_pkg::ST_GAP: begin
        if (cnt_done) begin
          state_next = irq_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = irq_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= irq_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // one counter times both phases from the system clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else if (state_next != state_reg || state_reg == irq_pkg::ST_IDLE) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // pin is driven low only while pulsing; no mode output exists here at all
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_out_n  <= 1'b1;
      irq_out_en <= 1'b0;
    end else begin
      irq_out_n  <= (state_next != irq_pkg::ST_PULSE);
      irq_out_en <= (mode != irq_pkg::MODE_INIT); // pin is an input while configuration sampled
    end
  end

  // ---------------------------------------------------------------------
  // host-visible status
  // ---------------------------------------------------------------------
  // snapshot at the falling edge; clears act directly on the visible copy
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_visible <= '{wake: irq_pkg::WAKE_RST, fail: irq_pkg::FAIL_RST};
    end else if (fall) begin
      status_visible <= '{wake: wake_lat_reg, fail: fail_lat_reg};
    end else begin
      if (clear_wake_primary) begin
        status_visible.wake[irq_pkg::WK_TIMER:irq_pkg::WK_CAN] <= 3'h0;
      end
      if (clear_wake_secondary) begin
        status_visible.wake[irq_pkg::WK_GPIO] <= 1'b0;
      end
      if (clear_fail) begin
        status_visible.fail <= irq_pkg::FAIL_RST;
      end
    end
  end

  // live levels, never latched
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_level_status <= 2'h0;
    end else begin
      wake_level_status <= {gp_lvl, wk_lvl};
    end
  end

  // gpio wake flag is set in restart too; fail-safe entry clears it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gpio_wake_event <= 1'b0;
    end else if (gpio_ev) begin
      gpio_wake_event <= 1'b1;
    end else if (clear_wake_secondary || mode == irq_pkg::MODE_FAILSAFE) begin
      gpio_wake_event <= 1'b0;
    end
  end

  // configuration level caught only while in init
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hw_config_sel <= 1'b0;
    end else if (mode == irq_pkg::MODE_INIT) begin
      hw_config_sel <= cfg_lvl;
    end
  end

  logic quiet_mode;

  // sleep and fail-safe mute the pin, so a wake edge wakes the device instead
  assign quiet_mode = (mode == irq_pkg::MODE_SLEEP) || (mode == irq_pkg::MODE_FAILSAFE);

  // one-cycle wake request towards the mode controller
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_device <= 1'b0;
    end else begin
      wake_device <= (|wake_hit) && quiet_mode;
    end
  end

endmodule

// ---- tb/sbc_irq_sva.sv ----
// checker: pulse timing, mode gating and status holding of the irq line
`timescale 1ns/1ps
module sbc_irq_sva #(
  parameter int PULSE_CYC     = 20,
  parameter int GAP_CYC       = 20,
  parameter int WAKE_FILT_CYC = 4
) (
  // clock and reset
  input wire logic               clk,
  input wire logic               arst_n,
  // block inputs
  input wire irq_pkg::sbc_mode_t mode,
  input wire irq_pkg::wake_src_t wake_enable,
  input wire logic               can_wake,
  input wire logic               wake_pin,
  input wire logic               clear_fail,
  input wire logic               clear_wake_secondary,
  // block outputs
  input wire logic               irq_out_n,
  input wire logic               irq_out_en,
  input wire irq_pkg::status_t   status_visible,
  input wire logic [1:0]         wake_level_status,
  input wire logic               gpio_wake_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // run-length counters
  // ----------------------------------------------------------------
  int   lo_cnt;
  int   hi_cnt;
  int   pin_cnt;
  logic pin_q;
  // high run starts saturated so the first pulse after reset is legal
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_cnt  <= 0;
      hi_cnt  <= GAP_CYC + 4;
      pin_cnt <= 0;
      pin_q   <= 1'b0;
    end else begin
      lo_cnt  <= irq_out_n ? 0 : lo_cnt + 1;
      hi_cnt  <= !irq_out_n ? 0 : (hi_cnt < GAP_CYC + 4 ? hi_cnt + 1 : hi_cnt);
      pin_q   <= wake_pin;
      pin_cnt <= (wake_pin != pin_q) ? 0 : (pin_cnt < 99 ? pin_cnt + 1 : pin_cnt);
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  pulse_width_a: assert property (
    $rose(irq_out_n) |-> lo_cnt == PULSE_CYC) else $error("pulse width wrong");
  gap_time_a: assert property (
    $fell(irq_out_n) |-> hi_cnt >= GAP_CYC) else $error("gap too short");
  mode_gate_a: assert property (
    $fell(irq_out_n) |-> $past(mode) inside {irq_pkg::MODE_NORMAL, irq_pkg::MODE_STOP})
    else $error("pulse in quiet mode");
  wake_pulse_a: assert property (
    mode == irq_pkg::MODE_NORMAL && can_wake && wake_enable.can && hi_cnt > GAP_CYC + 2
    |-> ##[1:2] !irq_out_n) else $error("wake gave no pulse");
  status_fall_a: assert property (
    |(status_visible & ~$past(status_visible)) |-> $fell(irq_out_n))
    else $error("status set off a falling edge");
  fail_hold_a: assert property (
    |($past(status_visible.fail) & ~status_visible.fail) |-> $past(clear_fail))
    else $error("fail status lost");
  gpio_hold_a: assert property (
    $fell(gpio_wake_event) |-> $past(clear_wake_secondary)
    || $past(mode) == irq_pkg::MODE_FAILSAFE) else $error("gpio flag lost");
  level_live_a: assert property (
    pin_cnt == WAKE_FILT_CYC + 4 |-> wake_level_status[0] == wake_pin)
    else $error("level status stale");
  out_enable_a: assert property (
    $past(arst_n) |-> irq_out_en == ($past(mode) != irq_pkg::MODE_INIT))
    else $error("pin enable wrong");
endmodule

bind sbc_interrupt_output sbc_irq_sva #(.PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC),
  .WAKE_FILT_CYC(WAKE_FILT_CYC)) chk_u (.clk, .arst_n, .mode, .wake_enable, .can_wake,
  .wake_pin, .clear_fail, .clear_wake_secondary, .irq_out_n, .irq_out_en,
  .status_visible, .wake_level_status, .gpio_wake_event);

// ---- tb/host_mcu.sv ----
// host model: answers an interrupt pulse by clearing the status after a delay
`timescale 1ns/1ps
module host_mcu (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // service on/off and answer delay
  input  wire logic       svc_en,
  input  wire logic [7:0] svc_dly,
  // interrupt line
  input  wire logic       irq_out_n,
  // clear strobes
  output logic            clr_p,
  output logic            clr_s,
  output logic            clr_f
);
  logic [7:0] cnt;
  logic       busy;
  logic       irq_q;
  // the confirming second read is optional and skipped here
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy  <= 1'b0;
      irq_q <= 1'b1;
      cnt   <= 8'h00;
      {clr_p, clr_s, clr_f} <= 3'h0;
    end else begin
      irq_q <= irq_out_n;
      {clr_p, clr_s, clr_f} <= 3'h0;
      if (irq_q && !irq_out_n && svc_en) begin
        busy <= 1'b1;
        cnt  <= svc_dly;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        {clr_p, clr_s, clr_f} <= 3'h7;
      end else if (busy)
        cnt <= cnt - 8'h01;
    end
  end
endmodule

// ---- tb/tb_sbc_interrupt_output.sv ----
// testbench: drives events and modes, measures the interrupt line
`timescale 1ns/1ps
module tb_sbc_interrupt_output;
  localparam int PW = 20;
  localparam int GP = 20;
  logic               clk, arst_n, cls, gwk, can, tmr, wpin, gpin, cfg, en;
  logic               cp, cs, cf, irq_n, oen, gev, sel, wdev, lo, wd;
  logic [7:0]         fev, fal, dly;
  logic [1:0]         lvl;
  irq_pkg::sbc_mode_t mode;
  irq_pkg::wake_src_t wen;
  irq_pkg::status_t   st;
  int                 err_count, samples_checked, c, w;

  sbc_interrupt_output #(.PULSE_CYC(PW), .GAP_CYC(GP), .WAKE_FILT_CYC(4), .CFG_FILT_CYC(4))
    dut_u (.clk(clk), .arst_n(arst_n), .mode(mode), .class_select(cls), .wake_enable(wen),
    .gpio_is_wake(gwk), .can_wake(can), .timer_wake(tmr), .wake_pin(wpin), .gpio_pin(gpin),
    .fail_event(fev), .fail_irq_allow(fal), .clear_wake_primary(cp),
    .clear_wake_secondary(cs), .clear_fail(cf), .irq_pin_in(cfg), .irq_out_n(irq_n),
    .irq_out_en(oen), .status_visible(st), .wake_level_status(lvl),
    .gpio_wake_event(gev), .hw_config_sel(sel), .wake_device(wdev));
  host_mcu host_u (.clk(clk), .arst_n(arst_n), .svc_en(en), .svc_dly(dly),
    .irq_out_n(irq_n), .clr_p(cp), .clr_s(cs), .clr_f(cf));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // inputs move 1 ns after the edge so sampling never races
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // event kind: 0 can, 1 wake pin edge, 2 timer, 3 gpio edge, else failure
  task automatic ev(input int k);
    case (k)
      0: can = 1'b1;
      1: wpin = ~wpin;
      2: tmr = 1'b1;
      3: gpin = ~gpin;
      default: fev = 8'h10;
    endcase
    step(1);
    can = 1'b0;
    tmr = 1'b0;
    fev = 8'h00;
  endtask
  // bounded wait for a line level; running out ends the run
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (irq_n !== v && n < 200) begin
      step(1);
      n++;
    end
    if (n >= 200) begin
      err_count++;
      give_verdict();
    end
  endtask
  // watch 30 cycles for any pulse or device wake
  task automatic see(output logic l, output logic d);
    l = 1'b0;
    d = 1'b0;
    repeat (30) begin
      step(1);
      l |= !irq_n;
      d |= wdev;
    end
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, cls, can, tmr, wpin, gpin} = 6'h00;
    {gwk, en, cfg} = 3'h7;
    mode = irq_pkg::MODE_INIT;
    wen = 4'hf;
    {fev, fal, dly} = 24'h000002;
    err_count = 0;
    samples_checked = 0;
    step(4);
    arst_n = 1'b1;
    step(8);
    chk({oen, sel, irq_n, st}, 16'h3000);
    $display("test reset done");
    mode = irq_pkg::MODE_NORMAL;
    cfg = 1'b0;
    step(4);
    for (int k = 0; k < 5; k++) begin
      ev(k == 4 ? 1 : k);
      wait_lvl(1'b0, c);
      chk(st.wake, 4'h1 << (k == 4 ? 1 : k));
      wait_lvl(1'b1, w);
      chk(w, PW);
      chk({oen, sel, wdev}, 3'b110);
      step(GP + 5);
    end
    chk(lvl, 2'h2);
    $display("test sources done");
    wen = 4'h7;
    ev(0);
    see(lo, wd);
    chk(lo, 1'b0);
    wen = 4'hf;
    gwk = 1'b0;
    ev(3);
    ev(3);
    ev(3);
    see(lo, wd);
    chk(lo, 1'b0);
    gwk = 1'b1;
    fal = 8'hff;
    ev(4);
    see(lo, wd);
    chk(lo, 1'b0);
    cls = 1'b1;
    fal = 8'hef;
    ev(4);
    see(lo, wd);
    chk(lo, 1'b0);
    fal = 8'hff;
    ev(4);
    wait_lvl(1'b0, c);
    chk(st.fail, 8'h10);
    wait_lvl(1'b1, w);
    step(GP + 5);
    cls = 1'b0;
    wpin = ~wpin;
    step(2);
    wpin = ~wpin;
    see(lo, wd);
    chk(lo, 1'b0);
    $display("test gating done");
    en = 1'b0;
    ev(0);
    wait_lvl(1'b0, c);
    ev(2);
    wait_lvl(1'b1, w);
    wait_lvl(1'b0, c);
    chk(c >= GP, 1'b1);
    chk(st.wake, 4'h5);
    wait_lvl(1'b1, w);
    step(GP + 5);
    mode = irq_pkg::MODE_STOP;
    wait_lvl(1'b0, c);
    chk(c <= 4, 1'b1);
    wait_lvl(1'b1, w);
    step(GP + 5);
    chk(st.wake, 4'h5);
    mode = irq_pkg::MODE_NORMAL;
    en = 1'b1;
    ev(0);
    wait_lvl(1'b0, c);
    wait_lvl(1'b1, w);
    step(GP + 5);
    chk(st, 12'h000);
    $display("test gap and stop done");
    mode = irq_pkg::MODE_SLEEP;
    step(2);
    ev(0);
    ev(1);
    see(lo, wd);
    chk({lo, wd}, 2'b01);
    mode = irq_pkg::MODE_RESTART;
    step(2);
    ev(0);
    ev(3);
    see(lo, wd);
    chk({lo, gev}, 2'b01);
    mode = irq_pkg::MODE_FAILSAFE;
    step(2);
    ev(0);
    see(lo, wd);
    chk({lo, gev}, 2'b00);
    $display("test modes done");
    give_verdict();
  end
endmodule
